// [odt_timestamp_insert.sv]
// Purpose: Stamps delay PDUs of the local MEP in both stream directions.
// Assumes: Preamble and start delimiter precede each frame body.
// Notes: Gaps between frames must exceed the delay line depth.
`timescale 1ns/1ps
`include "odt_consts.svh"

// ----------------------------------------------------------------------
// One stamping direction: classifier, stamp stage, delay line, rewriter.
// ----------------------------------------------------------------------
module odt_path
#(
   parameter bit IS_RX = 1'b0,
   parameter int DLY = `ODT_DLY_DEF,
   parameter int MAX_LABELS = `ODT_MAX_LABELS
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire odt_pkg::odt_byte_t i_d,
   input wire logic i_en,
   input wire odt_pkg::odt_stamp_t i_time,
   input wire odt_pkg::odt_stamp_t i_lat,
   input wire logic [2:0] i_mel,
   input wire logic i_eth_en,
   input wire logic i_mpls_en,
   output odt_pkg::odt_byte_t o_d,
   output logic o_en
);
   import odt_pkg::*;

   localparam odt_idx_t LBL_LAST = 11'(`ODT_LBL_S + 4 * (MAX_LABELS - 1));

   if (DLY < `ODT_DLY_MIN || DLY > `ODT_DLY_MAX || MAX_LABELS < 1)
   begin : g_bad_param
      $error("odt_path: delay depth or label count out of range.");
   end

   logic en_q;
   logic body_q;
   odt_idx_t idx_q;
   odt_idx_t len_q;
   logic len_ok_q;
   odt_stamp_t stamp_q;
   odt_byte_t b1_q;
   odt_byte_t b2_q;
   odt_byte_t b3_q;
   logic mpls_q;
   odt_idx_t pdu_q;
   logic hit_q;
   odt_idx_t woff_q;
   logic [31:0] crc_q;
   odt_beat_s dly_q [DLY];
   odt_beat_s tail;
   odt_idx_t fld;
   odt_byte_t tlv;
   logic op_ok;
   logic pdu_ok;
   logic sof;
   logic in_fcs;
   odt_idx_t rel;
   odt_idx_t frel;
   odt_byte_t out_d;

   assign sof = i_en && !en_q;
   assign tail = dly_q[DLY-1];

   // Tracks the frame body and the index of each body byte.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         en_q <= 1'b0;
         body_q <= 1'b0;
         idx_q <= 11'h000;
      end
      else if (i_ce)
      begin
         en_q <= i_en;
         if (!i_en)
            body_q <= 1'b0;
         else if (!body_q && i_d == `ODT_SFD)
         begin
            body_q <= 1'b1;
            idx_q <= 11'h000;
         end
         else if (body_q)
            idx_q <= idx_q + 11'h001;
      end
   end

   // Captures the corrected time at frame start and the frame length.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         stamp_q <= 64'h0000000000000000;
         len_q <= 11'h000;
         len_ok_q <= 1'b0;
      end
      else if (i_ce)
      begin
         if (sof)
         begin
            stamp_q <= IS_RX ? i_time - i_lat : i_time + i_lat;
            len_ok_q <= 1'b0;
         end
         else if (!i_en && en_q && body_q)
         begin
            len_q <= idx_q;
            len_ok_q <= 1'b1;
         end
      end
   end

   // Picks the stamp field and expected TLV offset from the opcode.
   always_comb
   begin
      fld = IS_RX ? `ODT_OFF_RXF : `ODT_OFF_TXF;
      tlv = `ODT_TLV_DM;
      op_ok = 1'b1;
      case (b2_q)
         `ODT_OP_1DM: tlv = `ODT_TLV_1DM;
         `ODT_OP_DMM: tlv = `ODT_TLV_DM;
         `ODT_OP_DMR: fld = IS_RX ? `ODT_OFF_RXB : `ODT_OFF_TXB;
         default: op_ok = 1'b0;
      endcase
      pdu_ok = op_ok && b3_q[7:5] == i_mel && b3_q[4:0] == 5'h00 &&
               b1_q == 8'h00 && i_d == tlv;
   end

   // Classifies the frame and latches the write offset on a match.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         b3_q <= 8'h00;
         mpls_q <= 1'b0;
         pdu_q <= 11'h000;
         hit_q <= 1'b0;
         woff_q <= 11'h000;
      end
      else if (i_ce)
      begin
         if (sof)
         begin
            mpls_q <= 1'b0;
            pdu_q <= 11'h000;
            hit_q <= 1'b0;
         end
         else if (i_en && body_q)
         begin
            b1_q <= i_d;
            b2_q <= b1_q;
            b3_q <= b2_q;
            if (idx_q == `ODT_ET_LO && {b1_q, i_d} == `ODT_ET_CFM && i_eth_en)
               pdu_q <= `ODT_PDU_ETH;
            if (idx_q == `ODT_ET_LO && {b1_q, i_d} == `ODT_ET_MPLS &&
                i_mpls_en)
               mpls_q <= 1'b1;
            if (mpls_q && pdu_q == 11'h000 &&
                idx_q >= `ODT_LBL_S + 11'h002 &&
                idx_q <= LBL_LAST + 11'h002 && idx_q[1:0] == 2'b10 &&
                i_d[0])
               pdu_q <= idx_q + `ODT_ACH_GAP;
            if (pdu_q != 11'h000 && idx_q == pdu_q + 11'h003 && pdu_ok)
            begin
               hit_q <= 1'b1;
               woff_q <= pdu_q + fld;
            end
         end
      end
   end

   // Delays every byte so the decision is known at the rewriter.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         for (int k = 0; k < DLY; k++)
            dly_q[k] <= '0;
      end
      else if (i_ce)
      begin
         dly_q[0] <= '{i_en, body_q && i_en, idx_q, i_d};
         for (int k = 1; k < DLY; k++)
            dly_q[k] <= dly_q[k-1];
      end
   end

   // Replaces the stamp bytes, then the frame check bytes, of a hit.
   always_comb
   begin
      out_d = tail.d;
      rel = tail.idx - woff_q;
      frel = tail.idx - (len_q - `ODT_FCS_LEN);
      in_fcs = len_ok_q && tail.idx >= len_q - `ODT_FCS_LEN;
      if (tail.body && hit_q && tail.idx >= woff_q &&
          rel < `ODT_STAMP_LEN && !in_fcs)
         out_d = stamp_q[{3'(3'h7 - rel[2:0]), 3'b000} +: 8];
      else if (tail.body && hit_q && in_fcs)
         out_d = ~crc_q[{frel[1:0], 3'b000} +: 8];
   end

   // Runs the frame check over the bytes as they leave.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         crc_q <= `ODT_CRC_INIT;
      else if (i_ce && tail.body && !in_fcs)
         crc_q <= odt_crc_byte(tail.idx == 11'h000 ? `ODT_CRC_INIT : crc_q,
                               out_d);
   end

   // Registers the outgoing stream; gaps and preamble keep their place.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_d <= 8'h00;
         o_en <= 1'b0;
      end
      else if (i_ce)
      begin
         o_d <= out_d;
         o_en <= tail.en;
      end
   end
endmodule

// ----------------------------------------------------------------------
// Device end: egress from the MAC to the line, ingress the other way.
// ----------------------------------------------------------------------
module odt_timestamp_insert
#(
   parameter int DLY = `ODT_DLY_DEF,
   parameter int MAX_LABELS = `ODT_MAX_LABELS
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   odt_mac_if.dev mac,
   input wire odt_pkg::odt_byte_t i_line_d,
   input wire logic i_line_en,
   output odt_pkg::odt_byte_t o_line_d,
   output logic o_line_en,
   input wire odt_pkg::odt_stamp_t i_time,
   input wire odt_pkg::odt_stamp_t i_latency,
   input wire logic [2:0] i_mel,
   input wire logic i_eth_en,
   input wire logic i_mpls_en
);
   import odt_pkg::*;

   odt_byte_t line_d_s1_q;
   odt_byte_t line_d_s2_q;
   logic line_en_s1_q;
   logic line_en_s2_q;

   // Brings the line pins into the clock domain.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         line_d_s1_q <= 8'h00;
         line_d_s2_q <= 8'h00;
         line_en_s1_q <= 1'b0;
         line_en_s2_q <= 1'b0;
      end
      else if (i_ce)
      begin
         line_d_s1_q <= i_line_d;
         line_d_s2_q <= line_d_s1_q;
         line_en_s1_q <= i_line_en;
         line_en_s2_q <= line_en_s1_q;
      end
   end

   odt_path #(.IS_RX(1'b0), .DLY(DLY), .MAX_LABELS(MAX_LABELS)) u_egress
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_d(mac.tx_d),
      .i_en(mac.tx_en),
      .i_time(i_time),
      .i_lat(i_latency),
      .i_mel(i_mel),
      .i_eth_en(i_eth_en),
      .i_mpls_en(i_mpls_en),
      .o_d(o_line_d),
      .o_en(o_line_en)
   );

   odt_path #(.IS_RX(1'b1), .DLY(DLY), .MAX_LABELS(MAX_LABELS)) u_ingress
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_d(line_d_s2_q),
      .i_en(line_en_s2_q),
      .i_time(i_time),
      .i_lat(i_latency),
      .i_mel(i_mel),
      .i_eth_en(i_eth_en),
      .i_mpls_en(i_mpls_en),
      .o_d(mac.rx_d),
      .o_en(mac.rx_dv)
   );
endmodule

// [odt_consts.svh]
// Purpose: Shared constants for the delay time-stamp insertion design.
// Assumes: Byte-wide GMII-style streams, Ethernet or MPLS-TP framing.
// Notes: Definitions only.
`ifndef ODT_CONSTS_SVH
`define ODT_CONSTS_SVH
`define ODT_PRE 8'h55
`define ODT_SFD 8'hd5
`define ODT_ET_CFM 16'h8902
`define ODT_ET_MPLS 16'h8847
`define ODT_OP_1DM 8'h2d
`define ODT_OP_DMR 8'h2e
`define ODT_OP_DMM 8'h2f
`define ODT_TLV_1DM 8'h10
`define ODT_TLV_DM 8'h20
`define ODT_ET_LO 11'h00d
`define ODT_PDU_ETH 11'h00e
`define ODT_LBL_S 11'h010
`define ODT_ACH_GAP 11'h006
`define ODT_OFF_TXF 11'h004
`define ODT_OFF_RXF 11'h00c
`define ODT_OFF_TXB 11'h014
`define ODT_OFF_RXB 11'h01c
`define ODT_STAMP_LEN 11'h008
`define ODT_FCS_LEN 11'h004
`define ODT_MIN_BODY 11'h03c
`define ODT_PRE_LEN 11'h008
`define ODT_IFG 11'h00c
`define ODT_CRC_INIT 32'hffffffff
`define ODT_CRC_POLY 32'hedb88320
`define ODT_DLY_DEF 8
`define ODT_DLY_MIN 5
`define ODT_DLY_MAX 11
`define ODT_MAX_LABELS 4
`define ODT_RX_BUF 64
`endif

// [odt_pkg.sv]
// Purpose: Types and the frame check function shared by both ends.
// Assumes: odt_consts.svh is on the include path.
// Notes: The CRC is the reflected Ethernet CRC-32, one byte per call.
`include "odt_consts.svh"
package odt_pkg;
   typedef logic [7:0] odt_byte_t;
   typedef logic [10:0] odt_idx_t;
   typedef logic [63:0] odt_stamp_t;
   typedef struct packed
   {
      logic en;
      logic body;
      odt_idx_t idx;
      odt_byte_t d;
   } odt_beat_s;
   typedef enum logic [2:0]
   {
      TX_IDLE = 3'b000,
      TX_PRE = 3'b001,
      TX_BODY = 3'b010,
      TX_FCS = 3'b011,
      TX_GAP = 3'b100
   } odt_tx_e;

   // Advances the running frame check value by one byte.
   function automatic logic [31:0] odt_crc_byte(input logic [31:0] c,
                                                input odt_byte_t d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int b = 0; b < 8; b++)
      begin
         r = r[0] ? ((r >> 1) ^ `ODT_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// [odt_mac_if.sv]
// Purpose: Byte stream link between the MEP host MAC and the stamping end.
// Assumes: Both ends run on one shared clock.
// Notes: tx flows host to device, rx flows device to host.
`timescale 1ns/1ps
interface odt_mac_if;
   logic [7:0] tx_d;
   logic tx_en;
   logic [7:0] rx_d;
   logic rx_dv;
   modport dev (input tx_d, input tx_en, output rx_d, output rx_dv);
   modport host (output tx_d, output tx_en, input rx_d, input rx_dv);
endinterface

// [odt_mep_host.sv]
// Purpose: MEP host end: originates, answers and collects delay PDUs.
// Assumes: Plain Ethernet framing; i_da and i_sa stay stable while busy.
// Notes: Received frames longer than the buffer are not answered.
`timescale 1ns/1ps
`include "odt_consts.svh"

module odt_mep_host
#(
   parameter int RX_BUF = `ODT_RX_BUF
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   odt_mac_if.host mac,
   input wire logic i_send,
   input wire logic i_send_dmm,
   input wire logic [2:0] i_mel,
   input wire logic [47:0] i_da,
   input wire logic [47:0] i_sa,
   output logic o_busy,
   output logic o_res_valid,
   output odt_pkg::odt_byte_t o_res_opcode,
   output odt_pkg::odt_stamp_t o_res_txf,
   output odt_pkg::odt_stamp_t o_res_rxf,
   output odt_pkg::odt_stamp_t o_res_txb,
   output odt_pkg::odt_stamp_t o_res_rxb
);
   import odt_pkg::*;

   localparam int AW = $clog2(RX_BUF);

   if (RX_BUF < 64 || RX_BUF > 1024)
   begin : g_bad_param
      $error("odt_mep_host: receive buffer size out of range.");
   end

   odt_tx_e st_q;
   odt_idx_t cnt_q;
   logic rep_q;
   logic dmm_q;
   logic rep_pend_q;
   logic [31:0] crc_q;
   odt_byte_t rbuf [RX_BUF];
   odt_idx_t rlen_q;
   logic ren_q;
   logic rbody_q;
   odt_idx_t ridx_q;
   logic rep_set;
   logic take;
   logic lock;
   odt_byte_t tb;
   odt_idx_t blen;

   // An answer reads the buffer ahead of the returning copy of itself, so
   // only bytes that the answer has not sent yet are kept from being
   // overwritten.
   assign lock = rep_q && st_q == TX_BODY && ridx_q >= cnt_q;
   assign take = st_q == TX_IDLE && rep_pend_q;
   assign rep_set = !mac.rx_dv && ren_q && rbody_q && !lock &&
                    ridx_q <= 11'(RX_BUF) &&
                    {rbuf[12], rbuf[13]} == `ODT_ET_CFM &&
                    rbuf[14][7:5] == i_mel && rbuf[15] == `ODT_OP_DMM;

   // Builds the next body byte: an answer or a fresh PDU.
   always_comb
   begin
      tb = 8'h00;
      blen = rep_q ? rlen_q : `ODT_MIN_BODY;
      if (rep_q)
      begin
         if (cnt_q < 11'h006)
            tb = rbuf[AW'(cnt_q + 11'h006)];
         else if (cnt_q < 11'h00c)
            tb = rbuf[AW'(cnt_q - 11'h006)];
         else if (cnt_q == `ODT_PDU_ETH + 11'h001)
            tb = `ODT_OP_DMR;
         else
            tb = rbuf[AW'(cnt_q)];
      end
      else if (cnt_q < 11'h006)
         tb = i_da[{3'(3'h5 - cnt_q[2:0]), 3'b000} +: 8];
      else if (cnt_q < 11'h00c)
         tb = i_sa[{3'(3'h5 - 3'(cnt_q[2:0] - 3'h6)), 3'b000} +: 8];
      else if (cnt_q == 11'h00c)
         tb = 8'(`ODT_ET_CFM >> 8);
      else if (cnt_q == 11'h00d)
         tb = 8'(`ODT_ET_CFM);
      else if (cnt_q == `ODT_PDU_ETH)
         tb = {i_mel, 5'h00};
      else if (cnt_q == `ODT_PDU_ETH + 11'h001)
         tb = dmm_q ? `ODT_OP_DMM : `ODT_OP_1DM;
      else if (cnt_q == `ODT_PDU_ETH + 11'h003)
         tb = dmm_q ? `ODT_TLV_DM : `ODT_TLV_1DM;
   end

   // Sends preamble, body, frame check and the gap in turn.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         st_q <= TX_IDLE;
         cnt_q <= 11'h000;
         rep_q <= 1'b0;
         dmm_q <= 1'b0;
         crc_q <= `ODT_CRC_INIT;
         mac.tx_d <= 8'h00;
         mac.tx_en <= 1'b0;
         o_busy <= 1'b0;
      end
      else if (i_ce)
      begin
         cnt_q <= cnt_q + 11'h001;
         case (st_q)
            TX_IDLE:
            begin
               cnt_q <= 11'h000;
               if (take || i_send)
               begin
                  rep_q <= take;
                  dmm_q <= i_send_dmm;
                  st_q <= TX_PRE;
                  o_busy <= 1'b1;
               end
            end
            TX_PRE:
            begin
               mac.tx_en <= 1'b1;
               mac.tx_d <= `ODT_PRE;
               if (cnt_q == `ODT_PRE_LEN - 11'h001)
               begin
                  mac.tx_d <= `ODT_SFD;
                  st_q <= TX_BODY;
                  cnt_q <= 11'h000;
               end
            end
            TX_BODY:
            begin
               mac.tx_d <= tb;
               crc_q <= odt_crc_byte(cnt_q == 11'h000 ? `ODT_CRC_INIT : crc_q,
                                     tb);
               if (cnt_q == blen - 11'h001)
               begin
                  st_q <= TX_FCS;
                  cnt_q <= 11'h000;
               end
            end
            TX_FCS:
            begin
               mac.tx_d <= ~crc_q[{cnt_q[1:0], 3'b000} +: 8];
               if (cnt_q == `ODT_FCS_LEN - 11'h001)
               begin
                  st_q <= TX_GAP;
                  cnt_q <= 11'h000;
               end
            end
            TX_GAP:
            begin
               mac.tx_en <= 1'b0;
               mac.tx_d <= 8'h00;
               if (cnt_q == `ODT_IFG - 11'h001)
               begin
                  st_q <= TX_IDLE;
                  o_busy <= 1'b0;
               end
            end
            default:
               st_q <= TX_IDLE;
         endcase
      end
   end

   // Holds an answer request; a new request wins over its taking.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         rep_pend_q <= 1'b0;
      else if (i_ce)
         rep_pend_q <= rep_set || (rep_pend_q && !take);
   end

   // Stores received bodies and reports stamps of 1DM and reply PDUs.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         ren_q <= 1'b0;
         rbody_q <= 1'b0;
         ridx_q <= 11'h000;
         rlen_q <= 11'h000;
         o_res_valid <= 1'b0;
         o_res_opcode <= 8'h00;
         o_res_txf <= 64'h0000000000000000;
         o_res_rxf <= 64'h0000000000000000;
         o_res_txb <= 64'h0000000000000000;
         o_res_rxb <= 64'h0000000000000000;
      end
      else if (i_ce)
      begin
         ren_q <= mac.rx_dv;
         o_res_valid <= 1'b0;
         if (!mac.rx_dv)
            rbody_q <= 1'b0;
         else if (!rbody_q && mac.rx_d == `ODT_SFD)
         begin
            rbody_q <= 1'b1;
            ridx_q <= 11'h000;
         end
         else if (rbody_q)
         begin
            ridx_q <= ridx_q + 11'h001;
            if (ridx_q < 11'(RX_BUF) && !lock)
               rbuf[AW'(ridx_q)] <= mac.rx_d;
         end
         if (rep_set)
            rlen_q <= ridx_q - `ODT_FCS_LEN;
         if (!mac.rx_dv && ren_q && rbody_q && !lock &&
             ridx_q <= 11'(RX_BUF) &&
             {rbuf[12], rbuf[13]} == `ODT_ET_CFM &&
             rbuf[14][7:5] == i_mel &&
             (rbuf[15] == `ODT_OP_1DM || rbuf[15] == `ODT_OP_DMR))
         begin
            o_res_valid <= 1'b1;
            o_res_opcode <= rbuf[15];
            for (int k = 0; k < 8; k++)
            begin
               o_res_txf[8*(7-k) +: 8] <= rbuf[18+k];
               o_res_rxf[8*(7-k) +: 8] <= rbuf[26+k];
               o_res_txb[8*(7-k) +: 8] <= rbuf[34+k];
               o_res_rxb[8*(7-k) +: 8] <= rbuf[42+k];
            end
         end
      end
   end
endmodule

// [odt_link_assertions.sv]
// Purpose: Checks framing on the byte link between the two ends.
// Assumes: Both streams share i_clk_sys; frames start with preamble.
// Notes: Gap counters saturate so long idle periods stay legal.
`timescale 1ns/1ps
module odt_link_assertions
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] tx_d,
   input wire logic tx_en,
   input wire logic [7:0] rx_d,
   input wire logic rx_dv
);
   logic [7:0] tx_idle_q;
   logic [7:0] rx_idle_q;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // -------------------------------------------------------------
   // Idle counters
   // -------------------------------------------------------------
   // Counts idle cycles on the host transmit stream.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || tx_en)
         tx_idle_q <= i_rst ? 8'hff : 8'h00;
      else if (tx_idle_q != 8'hff)
         tx_idle_q <= tx_idle_q + 8'h01;
   end

   // Counts idle cycles on the host receive stream.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || rx_dv)
         rx_idle_q <= i_rst ? 8'hff : 8'h00;
      else if (rx_idle_q != 8'hff)
         rx_idle_q <= rx_idle_q + 8'h01;
   end

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   a_tx_pre_shape: assert property ($rose(tx_en) |->
      (tx_d == 8'h55) [*7] ##1 tx_d == 8'hd5) else $error("tx preamble bad");
   a_rx_pre_shape: assert property ($rose(rx_dv) |->
      (rx_d == 8'h55) [*7] ##1 rx_d == 8'hd5) else $error("rx preamble bad");
   a_tx_gap_min: assert property ($rose(tx_en) |-> tx_idle_q >= 8'h0c)
      else $error("tx gap too short");
   a_rx_gap_min: assert property ($rose(rx_dv) |-> rx_idle_q >= 8'h0c)
      else $error("rx gap too short");
   a_tx_ether_type: assert property ($rose(tx_en) |->
      ##20 tx_d == 8'h89 ##1 tx_d == 8'h02) else $error("tx type bad");
   a_tx_pdu_head: assert property ($rose(tx_en) |->
      ##22 tx_d[4:0] == 5'h00 ##1 (tx_d inside {8'h2d, 8'h2e, 8'h2f})
      ##1 tx_d == 8'h00
      ##1 tx_d == (($past(tx_d, 2) == 8'h2d) ? 8'h10 : 8'h20))
      else $error("tx header bad");
   a_tx_stamp_empty: assert property ($rose(tx_en) ##23 tx_d != 8'h2e |->
      ##3 (tx_d == 8'h00) [*8]) else $error("tx stamp not empty");
   a_rx_pdu_head: assert property ($rose(rx_dv) |->
      ##22 rx_d[4:0] == 5'h00 ##1 (rx_d inside {8'h2d, 8'h2e, 8'h2f})
      ##1 rx_d == 8'h00) else $error("rx header bad");
endmodule

// [testbench.sv]
// Purpose: Runs delay frames from the host through the stamping end.
// Assumes: Line transmit is looped back to line receive.
// Notes: Time advances by one each cycle so stamps are predictable.
`timescale 1ns/1ps
module testbench;
   import odt_pkg::*;
   localparam odt_stamp_t lat_c = 64'h0000000000000123;
   logic clk;
   logic rst;
   logic send;
   logic send_dmm;
   logic [2:0] dev_mel;
   logic eth_en;
   logic mpls_en;
   odt_byte_t line_d;
   logic line_en;
   odt_byte_t out_d;
   logic out_en;
   odt_stamp_t tnow;
   logic busy;
   logic res_valid;
   logic match;
   logic tx_en_prev;
   logic line_en_prev;
   odt_byte_t res_op;
   odt_stamp_t res_txf, res_rxf, res_txb, res_rxb;
   odt_stamp_t te_q[$];
   odt_stamp_t ti_q[$];
   int failures;
   int tests_run;
   int cyc;
   logic [2:0] mel_tab [4] = '{3'h5, 3'h5, 3'h2, 3'h5};
   logic eth_tab [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic dmm_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

   // -------------------------------------------------------------
   // Design ends and checker
   // -------------------------------------------------------------
   odt_mac_if odt_mac_if_inst();
   odt_timestamp_insert odt_timestamp_insert_inst (.i_clk_sys(clk),
      .i_rst(rst), .i_ce(1'b1), .mac(odt_mac_if_inst), .i_line_d(line_d),
      .i_line_en(line_en), .o_line_d(out_d), .o_line_en(out_en),
      .i_time(tnow), .i_latency(lat_c), .i_mel(dev_mel), .i_eth_en(eth_en),
      .i_mpls_en(mpls_en));
   odt_mep_host odt_mep_host_inst (.i_clk_sys(clk), .i_rst(rst),
      .i_ce(1'b1), .mac(odt_mac_if_inst), .i_send(send),
      .i_send_dmm(send_dmm), .i_mel(3'h5), .i_da(48'h02aabbccdd01),
      .i_sa(48'h02aabbccdd02), .o_busy(busy), .o_res_valid(res_valid),
      .o_res_opcode(res_op), .o_res_txf(res_txf), .o_res_rxf(res_rxf),
      .o_res_txb(res_txb), .o_res_rxb(res_rxb));
   odt_link_assertions odt_link_assertions_inst (.i_clk_sys(clk),
      .i_rst(rst), .tx_d(odt_mac_if_inst.tx_d),
      .tx_en(odt_mac_if_inst.tx_en), .rx_d(odt_mac_if_inst.rx_d),
      .rx_dv(odt_mac_if_inst.rx_dv));

   // Makes the 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Advances time and loops the line stream back by one flop.
   always @(posedge clk)
   begin
      tnow <= tnow + 64'h1;
      line_d <= out_d;
      line_en <= out_en;
   end

   // Records the expected stamp at each frame start, both directions.
   always @(posedge clk)
   begin
      if (odt_mac_if_inst.tx_en === 1'b1 && tx_en_prev !== 1'b1)
         te_q.push_back(tnow + lat_c);
      if (line_en === 1'b1 && line_en_prev !== 1'b1)
         ti_q.push_back(tnow + 64'h2 - lat_c);
      tx_en_prev = odt_mac_if_inst.tx_en;
      line_en_prev = line_en;
   end

   // Cuts a hung run short.
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         failures++;
         print_verdict();
      end
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   // Compares one value and counts the outcome.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Launches one frame from the host.
   task automatic send_frame(input logic dmm);
      @(posedge clk);
      send <= 1'b1;
      send_dmm <= dmm;
      @(posedge clk);
      send <= 1'b0;
   endtask

   // Waits for the host result pulse, bounded.
   task automatic read_result();
      int n;
      n = 0;
      while (res_valid !== 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      check(res_valid, 64'h1);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Main sequence: matched 1DM, matched DMM, wrong level, type off.
   // -------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      send = 1'b0;
      send_dmm = 1'b0;
      dev_mel = 3'h5;
      eth_en = 1'b1;
      mpls_en = 1'b0;
      line_d = 8'h00;
      line_en = 1'b0;
      tnow = 64'h0001000000000000;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         dev_mel <= mel_tab[k];
         eth_en <= eth_tab[k];
         mpls_en <= !eth_tab[k];
         match = (mel_tab[k] == 3'h5) && eth_tab[k];
         te_q.delete();
         ti_q.delete();
         send_frame(dmm_tab[k]);
         read_result();
         check(res_op, dmm_tab[k] ? 64'h2e : 64'h2d);
         check(res_txf, match ? te_q[0] : 64'h0);
         check(res_rxf, match ? ti_q[0] : 64'h0);
         if (dmm_tab[k])
         begin
            check(res_txb, match ? te_q[1] : 64'h0);
            check(res_rxb, match ? ti_q[1] : 64'h0);
         end
         while (busy !== 1'b0)
            @(negedge clk);
      end
      print_verdict();
   end
endmodule
